/* inc/osa_pkg.sv */
// constants and carrier types for the origin search and position counter
`default_nettype none
package osa_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int HIGH_SPEED_HZ = 10000;
  localparam int CONSTANT_SPEED_HZ = 1000;
  localparam int JOG_DELAY_US = 1000;
  // longest pulse period rounds down, never below one cycle
  localparam int HS_DIV = (CLK_HZ / HIGH_SPEED_HZ) < 1 ? 1 :
                          CLK_HZ / HIGH_SPEED_HZ;
  localparam int CS_DIV = (CLK_HZ / CONSTANT_SPEED_HZ) < 1 ? 1 :
                          CLK_HZ / CONSTANT_SPEED_HZ;
  // least delay, cycles per microsecond round down
  localparam int JOG_DLY = (JOG_DELAY_US * (CLK_HZ / 1000000) + 0);
  localparam int DIV_W = 16;
  localparam int POS_W = 24;
  localparam logic [23:0] POS_RST = 24'h000000;
  localparam logic [23:0] POS_BAD = 24'h800000;
  localparam int SEN_ORG = 0;
  localparam int SEN_NEAR = 1;
  localparam int SEN_LIM = 2;
  localparam int SEN_PHASE = 3;
  localparam logic [3:0] SEN_RST = 4'hf;

  typedef enum logic [1:0] {
    two_sensor_ccw_edge_search = 2'h0,
    no_backlash_two_sensor_search = 2'h1,
    limit_as_origin_search = 2'h2,
    limit_as_origin_jog_search = 2'h3
  } osa_type_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_IDX = 3'h1,
    ST_SEEK = 3'h3,
    ST_SCAN = 3'h2,
    ST_FINE = 3'h6,
    ST_JOG = 3'h7,
    ST_FIN = 3'h5
  } osa_state_t;

  typedef struct packed {
    logic start;
    osa_type_t search_type;
    logic abort;
    logic pos_init;
    logic [23:0] init_val;
    logic pos_read;
    logic sel_pos;
    logic drv_reset_en;
    logic phase_and_en;
  } osa_cmd_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic error;
    logic found;
  } osa_stat_t;
endpackage
`default_nettype wire

/* src/osa_origin_search.sv */
// origin search sequencer and 24-bit position counter for one axis
// Summary of operation
// - two-sensor type: near phase, then origin phase
// - two-sensor type ends on origin ccw-side edge
// - no-backlash: constant scan to origin cw edge
// - limit types: limit cw-side edge is origin
// - jog variant repeats jog moves at the end
// - optional driver reset pulse on success
// - optional AND of origin with phase origin
// - position counters are 24 bits wide
// - position follows output pulses by direction
// - drive data bytes show position when selected
// - read command returns position
// - position valid within +-8388607
// - position clears to zero at reset
// - initialize command loads host value
// - remember origin, fast return when flag set
// - sensors are active low
`default_nettype none
module osa_origin_search #(
  parameter int CS_DIV_P = osa_pkg::CS_DIV,
  parameter int JOG_DLY_P = osa_pkg::JOG_DLY
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic origin_sensor_n,
  input wire logic near_origin_sensor_n,
  input wire logic ccw_limit_n,
  input wire logic phase_origin_in,
  input wire osa_pkg::osa_cmd_t cmd,
  output osa_pkg::osa_stat_t stat,
  output logic pulse_out,
  output logic dir_cw,
  output logic driver_reset_out,
  output logic [7:0] drive_data1,
  output logic [7:0] drive_data2,
  output logic [7:0] drive_data3,
  output logic [23:0] pos_read_data,
  output logic pos_read_valid
);
  import osa_pkg::*;

  logic [3:0] sen_s1_r;
  logic [3:0] sen_s2_r;
  logic [3:0] sen_pv_r;
  osa_state_t st_r;
  osa_state_t st_nxt;
  osa_type_t typ_r;
  osa_type_t last_typ_r;
  logic [DIV_W-1:0] div_r;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] org_pos_r;
  logic found_r;
  osa_stat_t stat_r;
  logic pulse_r;
  logic dir_r;
  logic drst_r;
  logic [23:0] dd_r;
  logic [23:0] rd_r;
  logic rdv_r;

  // stage one only feeds stage two; logic reads stage two and later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sen_s1_r <= SEN_RST;
      sen_s2_r <= SEN_RST;
      sen_pv_r <= SEN_RST;
    end else begin
      sen_s1_r <= {phase_origin_in, ccw_limit_n, near_origin_sensor_n,
                   origin_sensor_n};
      sen_s2_r <= sen_s1_r;
      sen_pv_r <= sen_s2_r;
    end
  end

  // no debounce here: chatter would be taken as real edges
  wire org_q_n = sen_s2_r[SEN_ORG] |
                 (cmd.phase_and_en & sen_s2_r[SEN_PHASE]);
  wire org_pv_n = sen_pv_r[SEN_ORG] |
                  (cmd.phase_and_en & sen_pv_r[SEN_PHASE]);
  wire org_on = ~org_q_n;
  wire near_on = ~sen_s2_r[SEN_NEAR];
  wire lim_on = ~sen_s2_r[SEN_LIM];
  // moving cw, sensor going off is its cw-side edge
  wire org_cw_edge = org_q_n & ~org_pv_n;
  wire org_ccw_edge = ~org_q_n & org_pv_n;
  wire near_cw_edge = sen_s2_r[SEN_NEAR] & ~sen_pv_r[SEN_NEAR];
  wire lim_cw_edge = sen_s2_r[SEN_LIM] & ~sen_pv_r[SEN_LIM];

  wire is_limit = (typ_r == limit_as_origin_search) |
                  (typ_r == limit_as_origin_jog_search);
  wire searching = (st_r != ST_IDLE) & (st_r != ST_FIN);
  wire org_fault = is_limit & searching & org_on;
  wire quit = cmd.abort | org_fault;
  wire div_zero = (div_r == '0);
  wire pos_bad = (pos_r == POS_BAD);
  wire at_target = (pos_r == org_pos_r);
  wire tgt_cw = $signed(org_pos_r) > $signed(pos_r);

  // speed and direction per phase
  wire moving = (st_r == ST_IDX) | (st_r == ST_SEEK) |
                (st_r == ST_SCAN) | (st_r == ST_FINE);
  wire fast = (st_r == ST_IDX) | (st_r == ST_SEEK);
  wire dir_nxt = (st_r == ST_IDX) ? tgt_cw : (st_r != ST_SEEK);
  wire step = moving & div_zero & ~(st_r == ST_IDX & at_target);
  wire jog_step = (st_r == ST_JOG) & div_zero & lim_on;
  wire any_step = step | jog_step;
  wire [DIV_W-1:0] reload = fast ? DIV_W'(HS_DIV) :
                            (st_r == ST_JOG) ? DIV_W'(JOG_DLY_P) :
                            DIV_W'(CS_DIV_P);

  wire start_ok = cmd.start & (st_r == ST_IDLE);
  wire keep_flag = found_r & (cmd.search_type == last_typ_r) & ~pos_bad;
  wire osa_state_t first_st =
    (cmd.search_type == no_backlash_two_sensor_search) ? ST_SCAN : ST_SEEK;
  wire osa_state_t after_idx =
    (typ_r == no_backlash_two_sensor_search) ? ST_SCAN : ST_SEEK;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd.start) begin
          st_nxt = keep_flag ? ST_IDX : first_st;
        end
      end
      ST_IDX: begin
        if (at_target) begin
          st_nxt = after_idx;
        end
      end
      ST_SEEK: begin
        if (is_limit ? lim_on : near_on) begin
          st_nxt = (typ_r == limit_as_origin_jog_search) ?
                   ST_JOG : ST_SCAN;
        end
      end
      ST_SCAN: begin
        unique case (typ_r)
          two_sensor_ccw_edge_search: begin
            if (near_cw_edge) begin
              st_nxt = ST_FINE;
            end
          end
          no_backlash_two_sensor_search: begin
            if (org_cw_edge) begin
              st_nxt = ST_FIN;
            end else if (near_cw_edge) begin
              st_nxt = ST_FINE;
            end
          end
          limit_as_origin_search: begin
            if (lim_cw_edge) begin
              st_nxt = ST_FIN;
            end
          end
          limit_as_origin_jog_search: begin
            st_nxt = ST_JOG;
          end
        endcase
      end
      ST_FINE: begin
        if (typ_r == two_sensor_ccw_edge_search ?
            org_ccw_edge : org_cw_edge) begin
          st_nxt = ST_FIN;
        end
      end
      ST_JOG: begin
        if (div_zero & ~lim_on) begin
          st_nxt = ST_FIN;
        end
      end
      ST_FIN: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (quit & searching) begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      typ_r <= two_sensor_ccw_edge_search;
      div_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (start_ok) begin
        typ_r <= cmd.search_type;
      end
      if (st_nxt != st_r) begin
        div_r <= '0;
      end else if (div_zero) begin
        div_r <= reload;
      end else begin
        div_r <= div_r - DIV_W'(1);
      end
    end
  end

  // origin memory follows address initialize so the spot stays physical
  wire [POS_W-1:0] init_delta = cmd.init_val - pos_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_r <= POS_RST;
      org_pos_r <= POS_RST;
      found_r <= 1'b0;
      last_typ_r <= two_sensor_ccw_edge_search;
    end else begin
      if (cmd.pos_init) begin
        pos_r <= cmd.init_val;
        org_pos_r <= org_pos_r + init_delta;
      end else if (any_step) begin
        pos_r <= dir_nxt ? pos_r + POS_W'(1) : pos_r - POS_W'(1);
      end
      if (st_r == ST_FIN) begin
        found_r <= 1'b1;
        last_typ_r <= typ_r;
        if (!cmd.pos_init) begin
          org_pos_r <= pos_r;
        end
      end else if ((quit & searching) | pos_bad |
                   (start_ok & ~keep_flag)) begin
        found_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
      pulse_r <= 1'b0;
      dir_r <= 1'b1;
      drst_r <= 1'b0;
      dd_r <= '0;
      rd_r <= '0;
      rdv_r <= 1'b0;
    end else begin
      stat_r.busy <= (st_nxt != ST_IDLE);
      stat_r.done <= (st_r == ST_FIN);
      stat_r.error <= quit & searching;
      stat_r.found <= found_r;
      pulse_r <= any_step;
      dir_r <= dir_nxt;
      drst_r <= (st_r == ST_FIN) & cmd.drv_reset_en;
      dd_r <= cmd.sel_pos ? pos_r : 24'h000000;
      rd_r <= cmd.pos_read ? pos_r : rd_r;
      rdv_r <= cmd.pos_read;
    end
  end

  assign stat = stat_r;
  assign pulse_out = pulse_r;
  assign dir_cw = dir_r;
  assign driver_reset_out = drst_r;
  assign drive_data1 = dd_r[7:0];
  assign drive_data2 = dd_r[15:8];
  assign drive_data3 = dd_r[23:16];
  assign pos_read_data = rd_r;
  assign pos_read_valid = rdv_r;

  chk_pos_load: assert property (@(posedge clk) disable iff (!rstn)
    cmd.pos_init |=> pos_r == $past(cmd.init_val))
    else $error("position not loaded");
  chk_pos_step: assert property (@(posedge clk) disable iff (!rstn)
    any_step && dir_nxt && !cmd.pos_init |=> pos_r == $past(pos_r) + 24'h1)
    else $error("position did not count up");
  chk_pulse_pos: assert property (@(posedge clk) disable iff (!rstn)
    pulse_out && !dir_cw && !$past(cmd.pos_init)
    |-> pos_r == $past(pos_r) - 24'h1)
    else $error("pulse and count disagree");
  chk_bytes_pos: assert property (@(posedge clk) disable iff (!rstn)
    cmd.sel_pos |=> {drive_data3, drive_data2, drive_data1} == $past(pos_r))
    else $error("drive bytes wrong");
  chk_read_reply: assert property (@(posedge clk) disable iff (!rstn)
    cmd.pos_read |=> pos_read_valid && pos_read_data == $past(pos_r))
    else $error("read reply wrong");
  chk_near_first: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ST_FINE && typ_r == two_sensor_ccw_edge_search
    |-> $past(st_r) inside {ST_SCAN, ST_FINE})
    else $error("origin phase before near phase");
  chk_limit_edge: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ST_SCAN && typ_r == limit_as_origin_search && !quit
    && lim_cw_edge |=> st_r == ST_FIN ##1 stat.done)
    else $error("limit edge not taken as origin");
  chk_org_watch: assert property (@(posedge clk) disable iff (!rstn)
    org_fault |=> st_r == ST_IDLE ##1 !stat.busy)
    else $error("origin fault not stopped");
  chk_drv_reset: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ST_FIN && cmd.drv_reset_en |=> driver_reset_out ##1
    !driver_reset_out)
    else $error("driver reset pulse wrong");
  chk_found_set: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ST_FIN |=> found_r ##1 stat.found)
    else $error("found flag not set");
endmodule
`default_nettype wire

/* tb/osa_mech_model.sv */
// carriage and sensor model moved by the step outputs
`default_nettype none
module osa_mech_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pulse_out,
  input wire logic dir_cw,
  input wire logic load,
  input wire logic [23:0] load_val,
  output logic origin_n,
  output logic near_n,
  output logic limit_n,
  output logic phase_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int p;
  // a counter preset stands for placing the carriage there
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p <= 0;
    end else if (load) begin
      p <= int'($signed(load_val));
    end else if (pulse_out) begin
      p <= dir_cw ? p + 1 : p - 1;
    end
  end
  // clean levels, low means on; origin zones kept clear of the limit
  // zones span many cycles per pulse, so every level outlasts the sync
  assign limit_n = !(p <= -3);
  assign near_n = !(p >= 8 && p <= 12);
  assign origin_n = !(p == 10 || p == 11 || p == 14 || p == 15);
  assign phase_n = p[0];
endmodule
`default_nettype wire

/* tb/origin_search_and_address_counter_tb_top.sv */
// self-checking bench for the origin search and position counter
`default_nettype none
module origin_search_and_address_counter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import osa_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  osa_cmd_t cmd = '0;
  osa_stat_t stat;
  logic pls, dir, drst, vld, org_n, near_n, lim_n, ph_n;
  logic [7:0] d1, d2, d3;
  logic [23:0] rd;
  int failures = 0;
  int n_tests = 0;
  int mpos = 0;
  int seed = 32'h3d7f;
  int i;
  always #12.5 clk = ~clk;

  osa_origin_search #(.CS_DIV_P(20), .JOG_DLY_P(20)) osa_origin_search_i (
    .clk(clk), .rstn(rstn), .origin_sensor_n(org_n),
    .near_origin_sensor_n(near_n), .ccw_limit_n(lim_n),
    .phase_origin_in(ph_n), .cmd(cmd), .stat(stat), .pulse_out(pls),
    .dir_cw(dir), .driver_reset_out(drst), .drive_data1(d1),
    .drive_data2(d2), .drive_data3(d3), .pos_read_data(rd),
    .pos_read_valid(vld)
  );
  osa_mech_model osa_mech_model_i (
    .clk(clk), .rstn(rstn), .pulse_out(pls), .dir_cw(dir),
    .load(cmd.pos_init), .load_val(cmd.init_val), .origin_n(org_n),
    .near_n(near_n), .limit_n(lim_n), .phase_n(ph_n)
  );

  // reference position, preset wins over a step
  always @(posedge clk) begin
    if (cmd.pos_init) begin
      mpos = int'($signed(cmd.init_val));
    end else if (rstn && pls === 1'b1) begin
      mpos = dir ? mpos + 1 : mpos - 1;
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic read_pos();
    @(posedge clk);
    cmd.pos_read <= 1'b1;
    @(posedge clk);
    cmd.pos_read <= 1'b0;
    #1;
    chk(vld === 1'b1 && rd === mpos[23:0], "read reply");
    chk({d3, d2, d1} === mpos[23:0], "drive bytes");
  endtask

  task automatic init(input logic [23:0] v);
    @(posedge clk);
    cmd.pos_init <= 1'b1;
    cmd.init_val <= v;
    @(posedge clk);
    cmd.pos_init <= 1'b0;
  endtask

  task automatic search(input osa_type_t t, input logic bad, input logic ab,
                        input int fin);
    int k;
    @(posedge clk);
    cmd.start <= 1'b1;
    cmd.search_type <= t;
    @(posedge clk);
    cmd.start <= 1'b0;
    #1;
    chk(stat.busy === 1'b1, "busy after start");
    k = 0;
    while (stat.done !== 1'b1 && stat.error !== 1'b1 && k < 60000) begin
      @(posedge clk);
      cmd.abort <= ab && k == 100;
      #1;
      k++;
    end
    chk(k < 60000, "search hang");
    chk(stat.error === bad && stat.done === !bad, "search end");
    chk(stat.busy === 1'b0, "busy after end");
    if (!bad) begin
      chk(drst === 1'b1, "reset pulse");
      chk(mpos == fin, "stop place");
      // found flag is registered once more, so it shows a cycle after done
      @(posedge clk);
      #1;
      chk(drst === 1'b0 && stat.found === 1'b1, "found flag");
    end
    read_pos();
    if (bad) begin
      chk(stat.found === 1'b0, "found kept");
    end
  endtask

  initial begin
    #(25 * 90000);
    failures++;
    finish_test();
  end

  initial begin
    cmd.sel_pos = 1'b1;
    cmd.drv_reset_en = 1'b1;
    repeat (11) @(posedge clk);
    #1;
    chk(stat === '0 && dir === 1'b1 && rd === '0 && d1 === '0, "reset");
    @(posedge clk);
    rstn <= 1'b1;
    read_pos();
    for (i = 0; i < 4; i++) begin
      init(24'($random(seed)));
      read_pos();
    end
    init(24'hd);
    search(two_sensor_ccw_edge_search, 1'b0, 1'b0, 14);
    init(24'ha);
    search(no_backlash_two_sensor_search, 1'b0, 1'b0, 12);
    cmd.phase_and_en <= 1'b1;
    init(24'ha);
    search(no_backlash_two_sensor_search, 1'b0, 1'b0, 11);
    cmd.phase_and_en <= 1'b0;
    init(24'he);
    search(limit_as_origin_search, 1'b1, 1'b0, 0);
    init(24'h0);
    search(limit_as_origin_search, 1'b0, 1'b0, -2);
    search(limit_as_origin_jog_search, 1'b0, 1'b0, -2);
    init(24'h5);
    search(limit_as_origin_jog_search, 1'b0, 1'b0, -2);
    init(24'h0);
    search(limit_as_origin_search, 1'b1, 1'b1, 0);
    finish_test();
  end
endmodule
`default_nettype wire
